/* File: rtl/apc_field_reg.sv */
// Module holding one 8-bit control register with reset value and implemented-bit mask.
`default_nettype none

module apc_field_reg #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] BIT_MASK  = 8'hff
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] value
);

   logic [7:0] reg_q;
   logic [7:0] reg_d;

   // Reserved bits are never stored, so they always read as zero.
   assign reg_d = wr_en ? (wdata & BIT_MASK) : reg_q;
   assign value = reg_q;

   // Storage with synchronous reset to the field defaults.
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_q <= RESET_VAL & BIT_MASK;
      end else begin
         reg_q <= reg_d;
      end
   end

endmodule

`default_nettype wire

/* File: rtl/apc_pkg.sv */
// Package holding the register map, field layout and value tables of the analog PLL controls.
`default_nettype none

package apc_pkg;

   // ***************************************************************
   // Register bus widths and offsets
   // ***************************************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   localparam logic [ADDR_W-1:0] ADDR_LOOP_FILTER = 16'h00ac;
   localparam logic [ADDR_W-1:0] ADDR_LOCK_MODE   = 16'h00ad;
   localparam logic [ADDR_W-1:0] ADDR_OSC1_LOCK   = 16'h00ae;
   localparam logic [ADDR_W-1:0] ADDR_OSC2_LOCK   = 16'h00af;

   // ***************************************************************
   // Reset values and masks of implemented bits
   // ***************************************************************
   localparam logic [DATA_W-1:0] RST_LOOP_FILTER  = 8'h8b;
   localparam logic [DATA_W-1:0] RST_LOCK_MODE    = 8'h02;
   localparam logic [DATA_W-1:0] RST_OSC1_LOCK    = 8'h2b;
   localparam logic [DATA_W-1:0] RST_OSC2_LOCK    = 8'h00;

   localparam logic [DATA_W-1:0] MASK_LOOP_FILTER = 8'hff;
   localparam logic [DATA_W-1:0] MASK_LOCK_MODE   = 8'h0b;
   localparam logic [DATA_W-1:0] MASK_OSC1_LOCK   = 8'h3f;
   localparam logic [DATA_W-1:0] MASK_OSC2_LOCK   = 8'h1f;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int PUMP_LSB   = 5;
   localparam int PUMP_W     = 3;
   localparam int SERIES_LSB = 3;
   localparam int SERIES_W   = 2;
   localparam int CAP_LSB    = 1;
   localparam int CAP_W      = 2;
   localparam int POLE_BIT   = 0;
   localparam int OVRD_BIT   = 0;
   localparam int ACC_BIT    = 1;
   localparam int SYNTH_BIT  = 3;
   localparam int OSC_BIT    = 5;
   localparam int CODE_LSB   = 0;
   localparam int CODE_W     = 5;

   // ***************************************************************
   // Analog value tables
   // ***************************************************************
   localparam int PUMP_UA_W   = 10;
   localparam int OHM_W       = 11;
   localparam int PF_W        = 8;
   localparam int PPM_W       = 5;

   localparam logic [PUMP_UA_W-1:0] PUMP_STEP_UA = 10'h06e;
   localparam logic [OHM_W-1:0]     SERIES_OHM_0 = 11'h14a;
   localparam logic [OHM_W-1:0]     SERIES_OHM_1 = 11'h280;
   localparam logic [OHM_W-1:0]     SERIES_OHM_2 = 11'h4b0;
   localparam logic [OHM_W-1:0]     SERIES_OHM_3 = 11'h6fe;
   localparam logic [PF_W-1:0]      CAP_PF_0     = 8'h28;
   localparam logic [PF_W-1:0]      CAP_PF_1     = 8'h50;
   localparam logic [PF_W-1:0]      CAP_PF_2     = 8'h8c;
   localparam logic [PF_W-1:0]      CAP_PF_3     = 8'hc8;
   localparam logic [OHM_W-1:0]     POST_OHM_LO  = 11'h1f1;
   localparam logic [OHM_W-1:0]     POST_OHM_HI  = 11'h62c;
   localparam logic [PF_W-1:0]      POST_CAP_PF  = 8'h28;
   localparam logic [PPM_W-1:0]     ACC_PPM_FINE = 5'h01;
   localparam logic [PPM_W-1:0]     ACC_PPM_WIDE = 5'h10;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic              wr_en;
      logic              rd_en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } apc_req_s;

   typedef struct packed {
      logic [PUMP_W-1:0]   pump_current_sel;
      logic [SERIES_W-1:0] series_resistor_sel;
      logic [CAP_W-1:0]    parallel_cap_sel;
      logic                second_pole_sel;
      logic                synthesizer_only_mode;
      logic                lock_count_accuracy;
      logic                lock_manual_override;
      logic                manual_osc_select;
      logic [CODE_W-1:0]   osc1_manual_lock_code;
      logic [CODE_W-1:0]   osc2_manual_lock_code;
   } apc_cfg_s;

   typedef struct packed {
      logic [PUMP_UA_W-1:0] pump_ua;
      logic [OHM_W-1:0]     series_ohm;
      logic [PF_W-1:0]      cap_pf;
      logic [OHM_W-1:0]     post_ohm;
      logic [PF_W-1:0]      post_pf;
      logic [PPM_W-1:0]     lock_ppm;
   } apc_analog_s;

endpackage

`default_nettype wire

/* File: rtl/apc_regs.sv */
// Analog PLL control register bank with decoded configuration outputs.
// Operation
// - Three-bit pump current code, 110 to 880 uA in steps, resets to 100.
// - Two-bit series resistor code, 330 ohm to 1.79 kohm, resets to 01.
// - Two-bit parallel capacitor code, 40 to 200 pF, resets to 01.
// - Second-pole bit picks low or high post resistance, 40 pF, resets to one.
// - Lock accuracy bit: zero means 1 ppm, one means 16 ppm; resets to one.
// - Manual override bit: zero automatic lock, one manual; resets to zero.
// - In manual mode oscillator bit zero picks second, one picks first; resets one.
// - Five-bit manual lock code of first oscillator, resets to 01011.
// - Five-bit manual lock code of second oscillator, resets to 00000.
// - Synthesizer bit: zero tracks references, one uses crystal only; resets zero.
// - Reserved bits are written as zero and their read value is ignored.
`default_nettype none

module apc_regs (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire apc_pkg::apc_req_s             req,
   output var  logic [apc_pkg::DATA_W-1:0]    rd_data_q,
   output var  logic                          rd_valid_q,
   output var  logic                          addr_miss_q,
   output var  apc_pkg::apc_cfg_s             cfg_q,
   output var  apc_pkg::apc_analog_s          analog_q,
   output var  logic                          manual_active_q,
   output var  logic                          osc1_selected_q,
   output var  logic [apc_pkg::CODE_W-1:0]    manual_lock_code_q,
   output var  logic                          freerun_required_q
);

   // ***************************************************************
   // Address decode
   // ***************************************************************
   logic                       hit_loop;
   logic                       hit_mode;
   logic                       hit_osc1;
   logic                       hit_osc2;
   logic                       hit_any;
   logic                       wr_loop;
   logic                       wr_mode;
   logic                       wr_osc1;
   logic                       wr_osc2;
   logic [apc_pkg::DATA_W-1:0] val_loop;
   logic [apc_pkg::DATA_W-1:0] val_mode;
   logic [apc_pkg::DATA_W-1:0] val_osc1;
   logic [apc_pkg::DATA_W-1:0] val_osc2;
   logic [apc_pkg::DATA_W-1:0] rd_mux;

   // Each register answers at exactly one address; other addresses miss.
   assign hit_loop = (req.addr == apc_pkg::ADDR_LOOP_FILTER);
   assign hit_mode = (req.addr == apc_pkg::ADDR_LOCK_MODE);
   assign hit_osc1 = (req.addr == apc_pkg::ADDR_OSC1_LOCK);
   assign hit_osc2 = (req.addr == apc_pkg::ADDR_OSC2_LOCK);
   assign hit_any  = hit_loop | hit_mode | hit_osc1 | hit_osc2;

   // Write strobes per register.
   // A read and a write in one cycle are both taken; the read sees the old value.
   assign wr_loop = req.wr_en & hit_loop;
   assign wr_mode = req.wr_en & hit_mode;
   assign wr_osc1 = req.wr_en & hit_osc1;
   assign wr_osc2 = req.wr_en & hit_osc2;

   // ***************************************************************
   // Register storage
   // ***************************************************************
   // The four registers share one module; only reset value and mask differ.
   // Ones written to reserved positions are dropped, so those bits stay zero.
   // register storage
   apc_field_reg #(
      .RESET_VAL (apc_pkg::RST_LOOP_FILTER),
      .BIT_MASK  (apc_pkg::MASK_LOOP_FILTER)
   ) u_loop_filter (
      .clk   (clk),
      .reset (reset),
      .wr_en (wr_loop),
      .wdata (req.wdata),
      .value (val_loop)
   );

   apc_field_reg #(
      .RESET_VAL (apc_pkg::RST_LOCK_MODE),
      .BIT_MASK  (apc_pkg::MASK_LOCK_MODE)
   ) u_lock_mode (
      .clk   (clk),
      .reset (reset),
      .wr_en (wr_mode),
      .wdata (req.wdata),
      .value (val_mode)
   );

   apc_field_reg #(
      .RESET_VAL (apc_pkg::RST_OSC1_LOCK),
      .BIT_MASK  (apc_pkg::MASK_OSC1_LOCK)
   ) u_osc1_lock (
      .clk   (clk),
      .reset (reset),
      .wr_en (wr_osc1),
      .wdata (req.wdata),
      .value (val_osc1)
   );

   apc_field_reg #(
      .RESET_VAL (apc_pkg::RST_OSC2_LOCK),
      .BIT_MASK  (apc_pkg::MASK_OSC2_LOCK)
   ) u_osc2_lock (
      .clk   (clk),
      .reset (reset),
      .wr_en (wr_osc2),
      .wdata (req.wdata),
      .value (val_osc2)
   );

   // ***************************************************************
   // Read path
   // ***************************************************************
   // reserved bits zero
   // Reserved bits are masked off in storage, so a read shows them as zero.
   // Unmapped addresses fall through every compare and select zero.
   assign rd_mux = hit_loop ? val_loop :
                   hit_mode ? val_mode :
                   hit_osc1 ? val_osc1 :
                   hit_osc2 ? val_osc2 : '0;

   logic                       any_access;
   logic [apc_pkg::DATA_W-1:0] rd_data_d;
   logic                       miss_d;

   // Next values of the read port; read data holds between reads.
   assign any_access = req.rd_en | req.wr_en;
   assign rd_data_d  = req.rd_en ? rd_mux : rd_data_q;
   assign miss_d     = any_access & ~hit_any;

   // Read data is registered one cycle after the request; a miss reads zero.
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   // The valid pulse stands for exactly one cycle after each read strobe.
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= req.rd_en;
      end
   end

   // An access outside the bank is flagged for one cycle and changes nothing.
   always_ff @(posedge clk) begin
      if (reset) begin
         addr_miss_q <= 1'b0;
      end else begin
         addr_miss_q <= miss_d;
      end
   end

   // ***************************************************************
   // Field extraction
   // ***************************************************************
   apc_pkg::apc_cfg_s cfg_d;

   // Fields are cut from the stored register values.
   // This copy is combinational; the output stage registers it for the ports.
   assign cfg_d.pump_current_sel =
      val_loop[apc_pkg::PUMP_LSB +: apc_pkg::PUMP_W];
   assign cfg_d.series_resistor_sel =
      val_loop[apc_pkg::SERIES_LSB +: apc_pkg::SERIES_W];
   assign cfg_d.parallel_cap_sel =
      val_loop[apc_pkg::CAP_LSB +: apc_pkg::CAP_W];
   assign cfg_d.second_pole_sel       = val_loop[apc_pkg::POLE_BIT];
   assign cfg_d.synthesizer_only_mode = val_mode[apc_pkg::SYNTH_BIT];
   assign cfg_d.lock_count_accuracy   = val_mode[apc_pkg::ACC_BIT];
   assign cfg_d.lock_manual_override  = val_mode[apc_pkg::OVRD_BIT];
   assign cfg_d.manual_osc_select     = val_osc1[apc_pkg::OSC_BIT];
   assign cfg_d.osc1_manual_lock_code =
      val_osc1[apc_pkg::CODE_LSB +: apc_pkg::CODE_W];
   assign cfg_d.osc2_manual_lock_code =
      val_osc2[apc_pkg::CODE_LSB +: apc_pkg::CODE_W];

   // ***************************************************************
   // Analog value decode
   // ***************************************************************
   // Analog values are carried for monitoring; the block drives no analog part.
   apc_pkg::apc_analog_s analog_d;
   logic [apc_pkg::PUMP_UA_W-1:0] pump_steps;

   // pump current steps
   // Code zero is one step, so the current is the step times code plus one.
   // The step and all table entries are package constants, so values are exact.
   assign pump_steps = apc_pkg::PUMP_UA_W'(cfg_d.pump_current_sel) + 10'h001;
   assign analog_d.pump_ua =
      apc_pkg::PUMP_UA_W'(pump_steps * apc_pkg::PUMP_STEP_UA);

   // series resistor table
   // Every code is legal and maps to one fixed resistance.
   assign analog_d.series_ohm =
      (cfg_d.series_resistor_sel == 2'h0) ? apc_pkg::SERIES_OHM_0 :
      (cfg_d.series_resistor_sel == 2'h1) ? apc_pkg::SERIES_OHM_1 :
      (cfg_d.series_resistor_sel == 2'h2) ? apc_pkg::SERIES_OHM_2 :
                                            apc_pkg::SERIES_OHM_3;

   // parallel capacitor table
   // Every code is legal and maps to one fixed capacitance.
   assign analog_d.cap_pf =
      (cfg_d.parallel_cap_sel == 2'h0) ? apc_pkg::CAP_PF_0 :
      (cfg_d.parallel_cap_sel == 2'h1) ? apc_pkg::CAP_PF_1 :
      (cfg_d.parallel_cap_sel == 2'h2) ? apc_pkg::CAP_PF_2 :
                                         apc_pkg::CAP_PF_3;

   // second pole values
   // The post-filter capacitor is the same for both settings.
   assign analog_d.post_ohm = cfg_d.second_pole_sel ? apc_pkg::POST_OHM_HI :
                                                      apc_pkg::POST_OHM_LO;
   assign analog_d.post_pf  = apc_pkg::POST_CAP_PF;

   // lock accuracy decode
   // Software picks the accuracy to suit the external loop capacitor.
   assign analog_d.lock_ppm = cfg_d.lock_count_accuracy ? apc_pkg::ACC_PPM_WIDE :
                                                          apc_pkg::ACC_PPM_FINE;

   // ***************************************************************
   // Lock mode selection
   // ***************************************************************
   logic                       manual_d;
   logic                       osc1_sel_d;
   logic [apc_pkg::CODE_W-1:0] chosen_code;
   logic [apc_pkg::CODE_W-1:0] code_d;

   // manual mode enable
   // Automatic mode hands oscillator choice and lock code to the lock logic.
   assign manual_d   = cfg_d.lock_manual_override;

   // manual oscillator choice
   // Select bit one picks the first oscillator's code, zero the second's.
   assign chosen_code = cfg_d.manual_osc_select ? cfg_d.osc1_manual_lock_code :
                                                  cfg_d.osc2_manual_lock_code;

   // In automatic mode the lock logic picks the oscillator, so no code is forced.
   assign osc1_sel_d = manual_d & cfg_d.manual_osc_select;
   assign code_d     = manual_d ? chosen_code : '0;

   // ***************************************************************
   // Output registers
   // ***************************************************************
   // Every output leaves from a flop, one cycle behind the stored registers.
   // The decoded field copy follows the bank one cycle late.
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_q <= '0;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // The analog values follow the same fields in the same cycle as the copy.
   always_ff @(posedge clk) begin
      if (reset) begin
         analog_q <= '0;
      end else begin
         analog_q <= analog_d;
      end
   end

   // Lock mode outputs; in automatic mode no oscillator or code is forced.
   always_ff @(posedge clk) begin
      if (reset) begin
         manual_active_q    <= 1'b0;
         osc1_selected_q    <= 1'b0;
         manual_lock_code_q <= '0;
      end else begin
         manual_active_q    <= manual_d;
         osc1_selected_q    <= osc1_sel_d;
         manual_lock_code_q <= code_d;
      end
   end

   // synthesizer mode output
   // The free-run demand tells the digital PLL side to force its free-run state.
   always_ff @(posedge clk) begin
      if (reset) begin
         freerun_required_q <= 1'b0;
      end else begin
         freerun_required_q <= cfg_d.synthesizer_only_mode;
      end
   end

endmodule

`default_nettype wire

/* File: testbench/apc_regs_props.sv */
// Checker of the read handshake and decoded outputs of the analog PLL control registers.
`default_nettype none
module apc_regs_props (
   input wire logic                             clk,
   input wire logic                             reset,
   input wire apc_pkg::apc_req_s                req,
   input wire logic                             rd_valid_q,
   input wire logic                             addr_miss_q,
   input wire apc_pkg::apc_cfg_s                cfg_q,
   input wire apc_pkg::apc_analog_s             analog_q,
   input wire logic                             manual_active_q,
   input wire logic                             osc1_selected_q,
   input wire logic [apc_pkg::CODE_W-1:0]       manual_lock_code_q,
   input wire logic                             freerun_required_q
);
   // ***************************************************************
   // Helper logic
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [1:0] up_q;
   wire logic  settled  = (up_q == 2'h3);
   wire logic  unmapped = (req.addr < apc_pkg::ADDR_LOOP_FILTER) ||
                          (req.addr > apc_pkg::ADDR_OSC2_LOCK);
   // Counts edges since reset so decoded outputs are judged once they settle.
   always_ff @(posedge clk) begin
      up_q <= reset ? 2'h0 : (settled ? up_q : up_q + 2'h1);
   end
   chk_read_answer: assert property (req.rd_en |=> rd_valid_q)
      else $error("read strobe got no valid pulse");
   chk_valid_cause: assert property (rd_valid_q |-> $past(req.rd_en))
      else $error("valid pulse without a read");
   chk_miss_pulse: assert property ((req.rd_en || req.wr_en) && unmapped
      |=> addr_miss_q) else $error("unmapped access not flagged");
   chk_write_lands: assert property (req.wr_en && req.addr == apc_pkg::ADDR_LOOP_FILTER
      |=> ##1 cfg_q.pump_current_sel == $past(req.wdata[7:5], 2)) else $error("pump write lost");
   chk_pump_scale: assert property (settled |-> analog_q.pump_ua ==
      ({7'h00, cfg_q.pump_current_sel} + 10'h001) * 10'h06e) else $error("pump current wrong");
   chk_lock_ppm: assert property (settled |-> analog_q.lock_ppm ==
      (cfg_q.lock_count_accuracy ? 5'h10 : 5'h01)) else $error("lock accuracy wrong");
   chk_post_pole: assert property (settled |-> analog_q.post_ohm ==
      (cfg_q.second_pole_sel ? 11'h62c : 11'h1f1)) else $error("post resistor wrong");
   chk_manual_code: assert property (settled |-> manual_lock_code_q ==
      (!cfg_q.lock_manual_override ? 5'h00 : cfg_q.manual_osc_select ?
      cfg_q.osc1_manual_lock_code : cfg_q.osc2_manual_lock_code)) else $error("lock code wrong");
   chk_osc_mode: assert property (settled |->
      manual_active_q == cfg_q.lock_manual_override &&
      osc1_selected_q == (cfg_q.lock_manual_override && cfg_q.manual_osc_select))
      else $error("manual mode flags wrong");
   chk_freerun_flag: assert property (settled |->
      freerun_required_q == cfg_q.synthesizer_only_mode) else $error("free-run flag wrong");
   cov_read: cover property (rd_valid_q);
   cov_miss: cover property (addr_miss_q);
   cov_osc1: cover property (osc1_selected_q);
   cov_freerun: cover property (freerun_required_q);
endmodule
bind apc_regs apc_regs_props chk_u (.clk(clk), .reset(reset), .req(req), .rd_valid_q(rd_valid_q),
   .addr_miss_q(addr_miss_q), .cfg_q(cfg_q), .analog_q(analog_q),
   .manual_active_q(manual_active_q), .osc1_selected_q(osc1_selected_q),
   .manual_lock_code_q(manual_lock_code_q), .freerun_required_q(freerun_required_q));
`default_nettype wire

/* File: testbench/test_apc_regs.sv */
// Self-checking bench of the analog PLL control register bank.
`default_nettype none
module test_apc_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk;
   logic                 reset;
   apc_pkg::apc_req_s    req;
   logic [7:0]           rd_data_q;
   logic                 rd_valid_q;
   logic                 addr_miss_q;
   apc_pkg::apc_cfg_s    cfg_q;
   apc_pkg::apc_analog_s analog_q;
   logic                 manual_active_q;
   logic                 osc1_selected_q;
   logic [4:0]           manual_lock_code_q;
   logic                 freerun_required_q;
   int                   bad_count;
   int                   cmp_count;
   logic [10:0]          ser_t [4] = '{11'h14a, 11'h280, 11'h4b0, 11'h6fe};
   logic [7:0]           cap_t [4] = '{8'h28, 8'h50, 8'h8c, 8'hc8};
   apc_regs dut_u (.clk(clk), .reset(reset), .req(req), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .addr_miss_q(addr_miss_q), .cfg_q(cfg_q), .analog_q(analog_q),
      .manual_active_q(manual_active_q), .osc1_selected_q(osc1_selected_q),
      .manual_lock_code_q(manual_lock_code_q), .freerun_required_q(freerun_required_q));
   // Free-running 20 MHz clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // Issues one write pulse and lets the register edge pass.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      req.wr_en = 1'b0;
   endtask
   // Issues one read pulse and judges the answer in the following cycle.
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge clk);
      req.rd_en = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd_en = 1'b0;
      check({31'h0, rd_valid_q}, 32'h1);
      check({24'h0, rd_data_q}, {24'h0, e});
   endtask
   // Waits until the decoded outputs follow the last write.
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   // Register and decoded defaults after reset.
   task automatic t_defaults();
      settle();
      rd(16'h00ac, 8'h8b);
      rd(16'h00ad, 8'h02);
      rd(16'h00ae, 8'h2b);
      rd(16'h00af, 8'h00);
      check({22'h0, analog_q.pump_ua}, 32'h226);
      check({21'h0, analog_q.series_ohm}, 32'h280);
      check({24'h0, analog_q.cap_pf}, 32'h50);
      check({21'h0, analog_q.post_ohm}, 32'h62c);
      check({24'h0, analog_q.post_pf}, 32'h28);
      check({30'h0, cfg_q.lock_count_accuracy, cfg_q.manual_osc_select}, 32'h3);
      check({27'h0, cfg_q.osc1_manual_lock_code}, 32'h0b);
      check({30'h0, manual_active_q, freerun_required_q}, 32'h0);
   endtask
   // Every pump, resistor, capacitor and pole code.
   task automatic t_loop_filter();
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         d = {i[2:0], i[1:0], i[2:1], i[0]};
         wr(16'h00ac, d);
         settle();
         check({22'h0, analog_q.pump_ua}, 32'(110 * (i + 1)));
         check({21'h0, analog_q.series_ohm}, {21'h0, ser_t[i[1:0]]});
         check({24'h0, analog_q.cap_pf}, {24'h0, cap_t[i[2:1]]});
         check({21'h0, analog_q.post_ohm}, i[0] ? 32'h62c : 32'h1f1);
         rd(16'h00ac, d);
      end
   endtask
   // Manual and automatic lock, oscillator choice, accuracy and synthesizer mode.
   task automatic t_lock_mode();
      wr(16'h00ad, 8'h0b);
      wr(16'h00ae, 8'h35);
      wr(16'h00af, 8'h0a);
      settle();
      rd(16'h00ad, 8'h0b);
      check({27'h0, manual_lock_code_q}, 32'h15);
      check({29'h0, manual_active_q, osc1_selected_q, freerun_required_q}, 32'h7);
      check({27'h0, analog_q.lock_ppm}, 32'h10);
      rd(16'h00ae, 8'h35);
      rd(16'h00af, 8'h0a);
      wr(16'h00ae, 8'h15);
      settle();
      check({27'h0, manual_lock_code_q}, 32'h0a);
      wr(16'h00ad, 8'h08);
      settle();
      check({27'h0, analog_q.lock_ppm}, 32'h01);
      check({26'h0, manual_lock_code_q, manual_active_q}, 32'h0);
      check({31'h0, freerun_required_q}, 32'h1);
      wr(16'h00ad, 8'h00);
      settle();
      check({31'h0, freerun_required_q}, 32'h0);
   endtask
   // Unmapped accesses are flagged and leave the bank untouched.
   task automatic t_unmapped();
      wr(16'h00ab, 8'h55);
      check({31'h0, addr_miss_q}, 32'h1);
      rd(16'h00b0, 8'h00);
      check({31'h0, addr_miss_q}, 32'h1);
      rd(16'h00ac, 8'hff);
   endtask
   // Ends the run with the verdict.
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #(5000 * 50);
      bad_count++;
      end_sim();
   end
   // Main sequence, including a second reset in mid-run.
   initial begin
      bad_count = 0;
      cmp_count = 0;
      req = '0;
      reset = 1'b1;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      t_defaults();
      t_loop_filter();
      t_lock_mode();
      t_unmapped();
      @(negedge clk);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      t_defaults();
      end_sim();
   end
endmodule
`default_nettype wire
